// *** hdl/ifct_pkg.sv ***
package ifct_pkg;

  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;

  // Register byte addresses.
  localparam logic [7:0] ADDR_FIFO_LEN = 8'h18;
  localparam logic [7:0] ADDR_RX_CNT   = 8'h20;
  localparam logic [7:0] ADDR_TX_CTL   = 8'h24;
  localparam logic [7:0] ADDR_DATA     = 8'h28;
  localparam logic [7:0] ADDR_ISTAT    = 8'h2c;
  localparam logic [7:0] ADDR_IMASK    = 8'h30;
  localparam logic [7:0] ADDR_CTRL     = 8'h34;

  // Field positions.
  localparam int unsigned RX_LVL_LSB   = 8;
  localparam int unsigned RX_CNT_W     = 8;
  localparam int unsigned TX_THD_LSB   = 8;
  localparam int unsigned TX_THD_W     = 4;
  localparam int unsigned TX_FLUSH_BIT = 7;
  localparam int unsigned TX_DEPTH_LSB = 8;
  localparam int unsigned CTRL_OPEN_RD = 0;

  // Interrupt status bits.
  localparam int unsigned IRQ_TX_THD  = 0;
  localparam int unsigned IRQ_LOCKOUT = 1;
  localparam int unsigned IRQ_RX_DONE = 2;
  localparam int unsigned IRQ_W       = 3;

  // FIFO shape and reset values.
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_CW    = 4;
  localparam int unsigned BYTE_W     = 8;
  localparam logic [7:0]  DEPTH_CODE = 8'h08;
  localparam logic [7:0]  RX_CNT_RST = 8'h01;
  localparam logic [3:0]  TX_THD_RST = 4'h0;
  localparam logic [8:0]  RX_LEN_MAX = 9'h100;

endpackage : ifct_pkg

// *** hdl/ifct_fifo.sv ***
`timescale 1ns/100ps
module ifct_fifo #(
  parameter int unsigned W  = 8,
  parameter int unsigned D  = 8,
  parameter int unsigned CW = 4
) (
  // Clock and reset.
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Discard all contents.
  input  wire logic          flush,
  // Fill side.
  input  wire logic          wr_valid,
  output logic               wr_ready,
  input  wire logic [W-1:0]  wr_data,
  // Drain side.
  output logic               rd_valid,
  input  wire logic          rd_ready,
  output logic [W-1:0]       rd_data,
  // Fill level.
  output logic [CW-1:0]      count
);

  localparam int unsigned PW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic          do_wr;
  logic          do_rd;

  assign wr_ready = (count != CW'(D)) && !flush;
  assign rd_valid = (count != '0) && !flush;
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;
  assign rd_data  = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= wr_ptr + PW'(do_wr);
      rd_ptr <= rd_ptr + PW'(do_rd);
      count  <= count + CW'(do_wr) - CW'(do_rd);
    end
  end

endmodule : ifct_fifo

// *** hdl/ifct_ctrl.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - The receive count register shows in bits 11:8 how many bytes the receive FIFO holds, 0 to 8.
// - Bits 7:0 of the receive count register give the controller read length, 1 to 256, with 0 meaning 256.
// - The read length resets to one.
// - The read length is ignored while interactive receive mode is enabled, which allows unlimited reads.
// - The transmit threshold flag is set whenever the transmit FIFO holds no more bytes than the 4-bit level.
// - Writing one to transmit flush bit 7 discards every byte in the transmit FIFO.
// - The transmit flush bit returns to zero when the flush is done, so zero means no flush in progress.
// - While the transmit lockout flag is set the flush bit reads one and the transmit FIFO stays flushed.
// - A lockout event from the protocol engine flushes the transmit FIFO, locks it and sets the lockout flag.
// - Read-only depth fields report 8-byte receive and transmit FIFOs.
module ifct_ctrl
  import ifct_pkg::*;
(
  // APB clock and reset.
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave.
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ifct_pkg::AW-1:0] paddr,
  input  wire logic [ifct_pkg::DW-1:0] pwdata,
  output logic      [ifct_pkg::DW-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Interrupt.
  output logic                         irq,
  // Transmit bytes towards the protocol engine.
  output logic                         tx_valid,
  input  wire logic                    tx_ready,
  output logic [ifct_pkg::BYTE_W-1:0]  tx_data,
  // Received bytes from the protocol engine.
  input  wire logic                    rx_valid,
  output logic                         rx_ready,
  input  wire logic [ifct_pkg::BYTE_W-1:0] rx_data,
  // Controller read sequencing.
  input  wire logic                    rd_start,
  output logic                         rx_ack_next,
  // Lockout request from the protocol engine.
  input  wire logic                    lockout_event
);

  import ifct_pkg::*;

  // Bus decode.
  wire setup_ph = psel && !penable;
  wire acc_ph   = psel && penable;
  wire wr_acc   = acc_ph && pwrite;
  wire rd_setup = setup_ph && !pwrite;

  wire hit_len   = (paddr == ADDR_FIFO_LEN);
  wire hit_rxcnt = (paddr == ADDR_RX_CNT);
  wire hit_txctl = (paddr == ADDR_TX_CTL);
  wire hit_data  = (paddr == ADDR_DATA);
  wire hit_istat = (paddr == ADDR_ISTAT);
  wire hit_imask = (paddr == ADDR_IMASK);
  wire hit_ctrl  = (paddr == ADDR_CTRL);
  wire hit_any   = hit_len | hit_rxcnt | hit_txctl | hit_data | hit_istat | hit_imask | hit_ctrl;

  wire wr_rxcnt = wr_acc && hit_rxcnt;
  wire wr_txctl = wr_acc && hit_txctl;
  wire wr_data  = wr_acc && hit_data;
  wire wr_istat = wr_acc && hit_istat;
  wire wr_imask = wr_acc && hit_imask;
  wire wr_ctrl  = wr_acc && hit_ctrl;

  // Software-visible state.
  logic [RX_CNT_W-1:0] rx_len;
  logic [TX_THD_W-1:0] tx_thd;
  logic                flush_pend;
  logic                open_rd_en;
  logic [IRQ_W-1:0]    istat;
  logic [IRQ_W-1:0]    imask;
  logic [8:0]          rx_got;
  logic                pslverr_q;

  // FIFO wiring.
  logic [FIFO_CW-1:0]  tx_count;
  logic [FIFO_CW-1:0]  rx_count;
  logic                rx_rd_valid;
  logic [BYTE_W-1:0]   rx_rd_data;
  logic [BYTE_W-1:0]   tx_fifo_data;

  wire lockout      = istat[IRQ_LOCKOUT];
  wire tx_flush     = flush_pend || lockout || lockout_event;
  wire flush_status = flush_pend || lockout;

  // Transmit data enters through the data register; writes are dropped when full or locked.
  wire tx_push = wr_data && !lockout;
  // Receive data leaves through the data register, popped as the read is captured.
  wire rx_pop  = rd_setup && hit_data;

  ifct_fifo #(
    .W  (BYTE_W),
    .D  (FIFO_DEPTH),
    .CW (FIFO_CW)
  ) u_tx_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (tx_flush),
    .wr_valid (tx_push),
    .wr_ready (),
    .wr_data  (pwdata[BYTE_W-1:0]),
    .rd_valid (tx_valid),
    .rd_ready (tx_ready),
    .rd_data  (tx_fifo_data),
    .count    (tx_count)
  );

  ifct_fifo #(
    .W  (BYTE_W),
    .D  (FIFO_DEPTH),
    .CW (FIFO_CW)
  ) u_rx_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .flush    (1'b0),
    .wr_valid (rx_valid),
    .wr_ready (rx_ready),
    .wr_data  (rx_data),
    .rd_valid (rx_rd_valid),
    .rd_ready (rx_pop),
    .rd_data  (rx_rd_data),
    .count    (rx_count)
  );

  assign tx_data = tx_fifo_data;

  // Controller read length and acknowledge decision.
  wire [8:0] rx_target = (rx_len == '0) ? RX_LEN_MAX : {1'b0, rx_len};
  wire       rx_take   = rx_valid && rx_ready;
  wire       last_byte = ((rx_got + 9'h001) == rx_target);
  assign rx_ack_next = open_rd_en || !last_byte;

  // Events.
  wire ev_tx_thd  = (FIFO_CW'(tx_thd) >= tx_count);
  wire ev_lockout = lockout_event;
  wire ev_rx_done = rx_take && last_byte && !open_rd_en;
  wire [IRQ_W-1:0] ev_vec = {ev_rx_done, ev_lockout, ev_tx_thd};

  // Status: an event in the clearing cycle wins over the clear.
  wire [IRQ_W-1:0] istat_clr  = wr_istat ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_istat = (istat & ~istat_clr) | ev_vec;

  assign irq = |(istat & imask);

  // Read mux.
  logic [DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_len) begin
      rd_mux[TX_DEPTH_LSB +: BYTE_W] = DEPTH_CODE;
      rd_mux[7:0]               = DEPTH_CODE;
    end
    if (hit_rxcnt) begin
      rd_mux[RX_LVL_LSB +: FIFO_CW] = rx_count;
      rd_mux[RX_CNT_W-1:0]          = rx_len;
    end
    if (hit_txctl) begin
      rd_mux[TX_THD_LSB +: TX_THD_W] = tx_thd;
      rd_mux[TX_FLUSH_BIT]           = flush_status;
    end
    if (hit_data) begin
      rd_mux[BYTE_W-1:0] = rx_rd_valid ? rx_rd_data : '0;
    end
    if (hit_istat) begin
      rd_mux[IRQ_W-1:0] = istat;
    end
    if (hit_imask) begin
      rd_mux[IRQ_W-1:0] = imask;
    end
    if (hit_ctrl) begin
      rd_mux[CTRL_OPEN_RD] = open_rd_en;
    end
  end

  // Bus answer: data captured in setup, answered in the first access cycle.
  assign pready  = 1'b1;
  assign pslverr = pslverr_q && acc_ph;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata    <= pwrite ? '0 : rd_mux;
      pslverr_q <= !hit_any;
    end
  end

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_len  <= RX_CNT_RST;
      tx_thd  <= TX_THD_RST;
      imask   <= '0;
      open_rd_en <= 1'b0;
    end else begin
      if (wr_rxcnt) begin
        rx_len <= pwdata[RX_CNT_W-1:0];
      end
      if (wr_txctl) begin
        tx_thd <= pwdata[TX_THD_LSB +: TX_THD_W];
      end
      if (wr_imask) begin
        imask <= pwdata[IRQ_W-1:0];
      end
      if (wr_ctrl) begin
        open_rd_en <= pwdata[CTRL_OPEN_RD];
      end
    end
  end

  // Flush request: set by a written one, cleared the cycle after the FIFO emptied.
  wire next_flush_pend = wr_txctl ? pwdata[TX_FLUSH_BIT] : 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush_pend <= 1'b0;
      istat      <= '0;
    end else begin
      flush_pend <= next_flush_pend || (flush_pend && (tx_count != '0));
      istat      <= next_istat;
    end
  end

  // Bytes received in the current controller read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_got <= '0;
    end else if (rd_start) begin
      rx_got <= '0;
    end else if (rx_take) begin
      rx_got <= last_byte ? '0 : rx_got + 9'h001;
    end
  end

endmodule : ifct_ctrl

// *** dv/ifct_ctrl_properties.sv ***
`timescale 1ns/100ps
module ifct_ctrl_properties
  import ifct_pkg::*;
(
  // Bus.
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ifct_pkg::AW-1:0] paddr,
  input wire logic [ifct_pkg::DW-1:0] pwdata,
  input wire logic [ifct_pkg::DW-1:0] prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // Engine side.
  input wire logic                    tx_valid,
  input wire logic                    tx_ready,
  input wire logic [7:0]              tx_data,
  input wire logic                    rx_valid,
  input wire logic                    rx_ready,
  input wire logic                    lockout_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire map = paddr inside {ADDR_FIFO_LEN, ADDR_RX_CNT, ADDR_TX_CTL, ADDR_DATA, ADDR_ISTAT, ADDR_IMASK, ADDR_CTRL};
  wire fwr = acc && pwrite && paddr == ADDR_TX_CTL && pwdata[TX_FLUSH_BIT];
  sequence s_tx_quiet;
    !tx_valid [*2];
  endsequence
  a_ready_zero_wait: assert property (acc |-> pready) else $error("pready low");
  a_err_unmapped_only: assert property (acc |-> pslverr == !map) else $error("bad pslverr");
  a_err_idle_low: assert property (!acc |-> !pslverr) else $error("pslverr when idle");
  a_rdata_held: assert property (acc |=> $stable(prdata)) else $error("prdata moved");
  a_flush_empties: assert property (fwr |=> s_tx_quiet) else $error("tx after flush");
  a_lockout_empties: assert property (lockout_event |=> s_tx_quiet) else $error("tx after lockout");
  a_tx_held: assert property (tx_valid && !tx_ready && !lockout_event && !fwr |=> tx_valid && $stable(tx_data))
    else $error("tx byte lost");
  a_rx_full_stop: assert property ($fell(rx_ready) |-> $past(rx_valid))
    else $error("rx_ready fell idle");
endmodule : ifct_ctrl_properties
bind ifct_ctrl ifct_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .lockout_event(lockout_event));

// *** dv/ifct_engine_model.sv ***
`timescale 1ns/100ps
module ifct_engine_model (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Transmit side.
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  // Receive side.
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ack_next,
  // Sequencing.
  output logic            rd_start,
  output logic            lockout_event
);
  int         stall = 0;
  logic [7:0] tx_q[$];
  logic       ack_q[$];
  initial begin
    {tx_ready, rx_valid, rd_start, lockout_event} = 4'h0;
    rx_data = 8'h00;
  end
  always @(posedge pclk) begin
    if (presetn && tx_valid && tx_ready)
      tx_q.push_back(tx_data);
    tx_ready <= stall == 0 || (stall == 1 && $urandom_range(1) == 1);
  end
  task send(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(negedge pclk);
    while (!rx_ready)
      @(negedge pclk);
    ack_q.push_back(rx_ack_next);
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= ~b;
  endtask : send
  task kick(input logic lock);
    @(posedge pclk);
    lockout_event <= lock;
    rd_start      <= !lock;
    @(posedge pclk);
    lockout_event <= 1'b0;
    rd_start      <= 1'b0;
  endtask : kick
endmodule : ifct_engine_model

// *** dv/ifct_ctrl_tb_top.sv ***
`timescale 1ns/100ps
module ifct_ctrl_tb_top;
  import ifct_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, rd_start, rx_ack_next, lockout_event;
  logic [7:0]  paddr, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  txq[$], rxq[$];
  int          miscompares = 0, cmp_count = 0, cycles = 0, n;
  int          lens[2] = '{2, 0};
  ifct_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rd_start(rd_start), .rx_ack_next(rx_ack_next), .lockout_event(lockout_event));
  ifct_engine_model eng (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_ack_next(rx_ack_next), .rd_start(rd_start), .lockout_event(lockout_event));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0, rd);
    chk($sformatf("reg %h", a), exp & m, rd & m);
  endtask : rdc
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'hd6b7eb50));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_FIFO_LEN, 32'h808);
    rdc(ADDR_RX_CNT, 32'h1);
    rdc(ADDR_TX_CTL, 32'h0);
    rdc(8'h40, 32'h0);
    apb(1'b1, ADDR_IMASK, 32'h4, rd);
    foreach (lens[k]) begin
      apb(1'b1, ADDR_RX_CNT, lens[k], rd);
      eng.kick(1'b0);
      n = lens[k] ? lens[k] : 256;
      for (int i = 0; i < n; i++) begin
        rxq.push_back(8'($urandom));
        eng.send(rxq[$]);
        chk("ack", i != n - 1, eng.ack_q.pop_front());
        rdc(ADDR_DATA, rxq.pop_front());
      end
      chk("irq", 1, irq);
      apb(1'b1, ADDR_ISTAT, 32'h4, rd);
      @(negedge pclk);
      chk("irq", 0, irq);
    end
    apb(1'b1, ADDR_CTRL, 32'h1, rd);
    eng.kick(1'b0);
    repeat (8) begin
      rxq.push_back(8'($urandom));
      eng.send(rxq[$]);
      chk("ack", 1, eng.ack_q.pop_front());
    end
    rdc(ADDR_RX_CNT, 32'h800);
    rdc(ADDR_ISTAT, 32'h0, 32'h4);
    repeat (8) rdc(ADDR_DATA, rxq.pop_front());
    rdc(ADDR_RX_CNT, 32'h0);
    eng.stall = 2;
    apb(1'b1, ADDR_TX_CTL, 32'h200, rd);
    repeat (5) begin
      txq.push_back(8'($urandom));
      apb(1'b1, ADDR_DATA, {24'h0, txq[$]}, rd);
    end
    apb(1'b1, ADDR_ISTAT, 32'h1, rd);
    rdc(ADDR_ISTAT, 32'h0, 32'h1);
    eng.stall = 1;
    n = 0;
    while (eng.tx_q.size() < 5 && n++ < 200) @(posedge pclk);
    foreach (txq[i]) chk("tx byte", txq[i], eng.tx_q[i]);
    rdc(ADDR_ISTAT, 32'h1, 32'h1);
    eng.stall = 2;
    repeat (3) apb(1'b1, ADDR_DATA, $urandom, rd);
    apb(1'b1, ADDR_TX_CTL, 32'h280, rd);
    repeat (2) @(posedge pclk);
    rdc(ADDR_TX_CTL, 32'h200);
    eng.stall = 0;
    repeat (4) @(posedge pclk);
    chk("tx count", 5, eng.tx_q.size());
    eng.kick(1'b1);
    rdc(ADDR_TX_CTL, 32'h80, 32'h80);
    apb(1'b1, ADDR_DATA, 32'h5a, rd);
    repeat (4) @(posedge pclk);
    chk("tx count", 5, eng.tx_q.size());
    rdc(ADDR_ISTAT, 32'h2, 32'h2);
    apb(1'b1, ADDR_ISTAT, 32'h2, rd);
    repeat (2) @(posedge pclk);
    rdc(ADDR_TX_CTL, 32'h200);
    results();
  end
endmodule : ifct_ctrl_tb_top
